// ==== testbench/t1rir_asserts.sv ====
/* Checker on the status block ports: read answer, mask refresh,
   clear on write-back and flag latching. Bound onto t1rir_status. */
`timescale 1ns/1ps
`default_nettype none
module t1rir_asserts (
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst_b,
   // Control port
   input wire logic       i_ce,
   input wire logic       i_bus_wr,
   input wire logic       i_bus_rd,
   input wire logic [7:0] i_bus_addr,
   input wire logic [7:0] i_bus_wdata,
   input wire logic [7:0] o_bus_rdata,
   // Watched causes
   input wire logic       i_align_change,
   input wire logic       i_tx_store_empty,
   input wire logic       i_jitter_near_limit
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // Taken strobes
   wire logic wr  = i_ce && i_bus_wr;
   wire logic rd  = i_ce && i_bus_rd;
   // Address decode
   wire logic a10 = i_bus_addr == t1rir_pkg::ADDR_LEVEL_CLOCK;
   wire logic a22 = i_bus_addr == t1rir_pkg::ADDR_FRAMING_EVT;
   wire logic a31 = i_bus_addr == t1rir_pkg::ADDR_ALARM_SLIP;
   // Unmapped read gives the fixed byte
   property p_unmapped;
      rd && !(a10 || a22 || a31) |=> o_bus_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   // Read data stands until the next read
   property p_hold;
      !rd |=> $stable(o_bus_rdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved without a read");
   // Spare level bits read zero
   property p_spare;
      rd && a10 |=> (o_bus_rdata & t1rir_pkg::LEVEL_UNUSED_MASK) == 8'h00;
   endproperty
   a_spare: assert property (p_spare)
      else $error("spare bits not zero");
   // Alignment change seen by a mask poll
   property p_align;
      i_align_change [*2] ##0 (wr && a22 && i_bus_wdata[7])
         ##1 (rd && a22) |=> o_bus_rdata[7];
   endproperty
   a_align: assert property (p_align)
      else $error("alignment flag missing");
   // Transmit empty sets empty and slip together
   property p_slip;
      i_tx_store_empty [*2] ##0 (wr && a31 && i_bus_wdata[4]
         && i_bus_wdata[3]) ##1 (rd && a31) |=> o_bus_rdata[4:3] == 2'h3;
   endproperty
   a_slip: assert property (p_slip)
      else $error("slip flags missing");
   // Jitter level keeps its flag set
   property p_jitter;
      i_jitter_near_limit [*2] ##0 (wr && a10 && i_bus_wdata[5])
         ##1 (rd && a10) |=> o_bus_rdata[5];
   endproperty
   a_jitter: assert property (p_jitter)
      else $error("jitter flag missing");
   // Write-back of a set bit clears it for the next poll
   property p_clear;
      (rd && a22) ##1 (!i_align_change throughout ((wr && a22
         && i_bus_wdata[7] && o_bus_rdata[7]) ##[2:4] (wr && a22
         && i_bus_wdata[7]) ##1 (rd && a22))) |=> !o_bus_rdata[7];
   endproperty
   a_clear: assert property (p_clear)
      else $error("flag survived write-back");
   // Zero mask holds the whole shadow byte
   property p_mask_hold;
      (rd && a31) ##1 (wr && a31 && i_bus_wdata == 8'h00) ##1 (rd && a31)
         |=> o_bus_rdata == $past(o_bus_rdata, 2);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("zero mask changed shadow");
endmodule
`default_nettype wire

// ==== testbench/t1rir_host.sv ====
/* Host model on the control port: single cycles and the mask write,
   read, masked write-back poll. Assumes strobes taken on rising i_clk. */
`timescale 1ns/1ps
`default_nettype none
module t1rir_host (
   // Clock and read data
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   // Strobes and bytes
   output var  logic       o_wr,
   output var  logic       o_rd,
   output var  logic [7:0] o_addr,
   output var  logic [7:0] o_wdata
);
   // Idle from time zero
   initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
   // One cycle, driven just after the edge
   task automatic cyc(input logic w, r, input logic [7:0] a, d);
      @(posedge i_clk);
      #1;
      {o_wr, o_rd, o_addr, o_wdata} = {w, r, a, d};
   endtask
   // Mask, read, write back the read byte ANDed with the mask
   task automatic poll(input logic [7:0] a, m, output logic [7:0] v);
      cyc(1'b1, 1'b0, a, m);
      cyc(1'b0, 1'b1, a, m);
      @(posedge i_clk);
      #1;
      v = i_rdata;
      {o_wr, o_rd, o_wdata} = {1'b1, 1'b0, v & m};
      cyc(1'b0, 1'b0, a, 8'h00);
   endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/* Bench top: status block, host model, bound checker. Assumes a
   10 MHz clock and a short carrier loss count of 20 zeros. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   localparam logic [7:0] A10 = t1rir_pkg::ADDR_LEVEL_CLOCK;
   localparam logic [7:0] A22 = t1rir_pkg::ADDR_FRAMING_EVT;
   localparam logic [7:0] A31 = t1rir_pkg::ADDR_ALARM_SLIP;
   // Flag mask of each event input, in ev order
   localparam logic [7:0] EVM [13] = '{8'h80, 8'h04, 8'h02, 8'h01,
      8'h10, 8'h08, 8'h80, 8'h04, 8'h02, 8'h01, 8'h28, 8'h18, 8'h40};
   logic        clk     = 1'b0;   // System clock
   logic        rst_b   = 1'b0;   // Reset, active low
   logic        ce      = 1'b1;   // Clock enable
   logic        rclk    = 1'b0;   // Receive line clock
   logic        rclk_en = 1'b0;   // Line clock gate
   logic        pos     = 1'b0;   // Positive rail
   logic        jit     = 1'b0;   // Jitter near limit
   logic [1:0]  lvl     = 2'h0;   // Receive level code
   logic [12:0] ev      = 13'h0;  // Event pulses
   wire logic   wr, rd;           // Host strobes
   wire logic [7:0] addr, wdata, rdata;
   int          n_errors = 0;
   int          checked  = 0;
   // Clocks; line clock is slower and unrelated in phase
   always #50 clk = ~clk;
   always #140 if (rclk_en) rclk = ~rclk;
   t1rir_status #(.LOSS_ZEROS(20)) u_t1rir_status (.i_clk(clk),
      .i_rst_b(rst_b), .i_ce(ce), .i_bus_wr(wr), .i_bus_rd(rd),
      .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
      .i_rx_clock_in(rclk), .i_rx_positive_rail_in(pos),
      .i_rx_negative_rail_in(1'b0), .i_align_change(ev[0]),
      .i_severe_framing(ev[1]), .i_b8zs_code(ev[2]),
      .i_frame_bit_err(ev[3]), .i_rx_store_full(ev[4]),
      .i_rx_store_empty(ev[5]), .i_sync_regained(ev[6]),
      .i_blue_cleared(ev[7]), .i_rx_density_viol(ev[8]),
      .i_tx_density_viol(ev[9]), .i_tx_store_full(ev[10]),
      .i_tx_store_empty(ev[11]), .i_carrier_restored(ev[12]),
      .i_jitter_near_limit(jit), .i_rx_level(lvl));
   t1rir_host u_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr),
      .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   // Counts, verdict, end of run
   task automatic print_verdict();
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Poll and compare the masked byte
   task automatic pchk(input logic [7:0] a, m, e);
      logic [7:0] v;
      u_host.poll(a, m, v);
      `CHK(v & m, e)
   endtask
   // Reset values and an unmapped address
   task automatic t_reset();
      pchk(A10, 8'hff, t1rir_pkg::FLAGS_RESET);
      pchk(A22, 8'hff, t1rir_pkg::FLAGS_RESET);
      pchk(A31, 8'hff, t1rir_pkg::FLAGS_RESET);
      pchk(8'h55, 8'hff, t1rir_pkg::UNMAPPED_DATA);
      $display("test reset done");
   endtask
   // Every event sets its bits, then reads clear
   task automatic t_events();
      for (int k = 0; k < 13; k++) begin
         ev[k] = 1'b1;
         fork
            pchk(k < 6 ? A22 : A31, EVM[k], EVM[k]);
            begin
               repeat (2) @(posedge clk);
               #1 ev[k] = 1'b0;
            end
         join
         pchk(k < 6 ? A22 : A31, EVM[k], 8'h00);
      end
      $display("test events done");
   endtask
   // Zero mask keeps the old byte while a flag waits
   task automatic t_hold();
      ev[7] = 1'b1;
      u_host.cyc(1'b0, 1'b1, A31, 8'h00);
      ev[7] = 1'b0;
      u_host.cyc(1'b1, 1'b0, A31, 8'h00);
      `CHK(rdata, 8'h00)
      u_host.cyc(1'b0, 1'b1, A31, 8'h00);
      u_host.cyc(1'b0, 1'b0, A31, 8'h00);
      `CHK(rdata, 8'h00)
      pchk(A31, 8'h04, 8'h04);
      $display("test hold done");
   endtask
   // Events while frozen by the clock enable leave no trace
   task automatic t_freeze();
      ce = 1'b0;
      ev[0] = 1'b1;
      @(posedge clk);
      #1;
      ev[0] = 1'b0;
      ce = 1'b1;
      pchk(A22, 8'h80, 8'h00);
      $display("test freeze done");
   endtask
   // All level codes, then the jitter level flag
   task automatic t_level();
      for (int lv = 0; lv < 4; lv++) begin
         lvl = 2'(lv);
         pchk(A10, 8'hc7, {2'(lv), 6'h00});
      end
      jit = 1'b1;
      pchk(A10, 8'h20, 8'h20);
      jit = 1'b0;
      pchk(A10, 8'h20, 8'h00);
      $display("test level done");
   endtask
   // Zero runs, carrier loss, clock loss and recovery
   task automatic t_line();
      rclk_en = 1'b1;
      repeat (80) @(posedge clk);
      pchk(A22, 8'h60, 8'h60);
      pchk(A10, 8'h18, 8'h18);
      pchk(A10, 8'h18, 8'h08);
      rclk_en = 1'b0;
      repeat (40) @(posedge clk);
      pchk(A10, 8'h10, 8'h10);
      rclk_en = 1'b1;
      pos = 1'b1;
      repeat (800) @(posedge clk);
      pchk(A10, 8'h18, 8'h00);
      $display("test line done");
   endtask
   // Main sequence after three reset cycles
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      t_reset();
      t_events();
      t_hold();
      t_freeze();
      t_level();
      t_line();
      print_verdict();
   end
   // Watchdog, about four and a half times the expected run
   initial begin
      #500000;
      n_errors++;
      print_verdict();
   end
endmodule
bind t1rir_status t1rir_asserts u_t1rir_asserts (.i_clk, .i_rst_b,
   .i_ce, .i_bus_wr, .i_bus_rd, .i_bus_addr, .i_bus_wdata, .o_bus_rdata,
   .i_align_change, .i_tx_store_empty, .i_jitter_near_limit);
`default_nettype wire

// ==== verilog/t1rir_clock_mon.sv ====
/*
 * Receive clock watchdog: finds rising edges of the synchronised
 * receive clock and flags a missing clock after a quiet period.
 * Assumes the clock level arrives already through two flops.
 */
`timescale 1ns/1ps
`default_nettype none

module t1rir_clock_mon #(
   parameter int unsigned LOSS_CYC = t1rir_pkg::CLOCK_LOSS_CYC
) (
   // Clock, reset, enable
   input  wire logic     i_clk,
   input  wire logic     i_rst_b,
   input  wire logic     i_ce,
   // Link to core
   t1rir_line_if.clk_mon lnk
);
   localparam int unsigned CW = $clog2(LOSS_CYC + 1);

   initial begin
      if (LOSS_CYC < 1) begin
         $error("LOSS_CYC must be at least one");
      end
   end

   logic          prev_q, prev_d;   // Clock level last cycle
   logic [CW-1:0] quiet_q, quiet_d; // Cycles since a transition

   // Edge and quiet time
   always_comb begin
      prev_d  = prev_q;
      quiet_d = quiet_q;
      if (i_ce) begin
         prev_d = lnk.rclk_s;
         if (lnk.rclk_s != prev_q) begin
            quiet_d = '0;              // Any transition restarts
         end else if (quiet_q != CW'(LOSS_CYC)) begin
            quiet_d = quiet_q + CW'(1); // Saturating count
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         prev_q  <= 1'b0;
         quiet_q <= '0;
      end else begin
         prev_q  <= prev_d;
         quiet_q <= quiet_d;
      end
   end

   // Rising edge marks one line bit
   assign lnk.bit_stb  = i_ce & lnk.rclk_s & ~prev_q;
   // Clock lost once quiet for the least loss time
   assign lnk.clk_lost = (quiet_q == CW'(LOSS_CYC));
endmodule

`default_nettype wire

// ==== verilog/t1rir_line_if.sv ====
/*
 * Carrier between the status core and its two line monitors.
 * Assumes all signals are on the system clock domain and the
 * core has already synchronised the line pins.
 */
`timescale 1ns/1ps
`default_nettype none

interface t1rir_line_if;
   logic rclk_s;        // Synchronised receive clock level
   logic pos_s;         // Synchronised positive rail
   logic neg_s;         // Synchronised negative rail
   logic bit_stb;       // One line bit sampled this cycle
   logic clk_lost;      // Receive clock missing, level
   logic zero8_p;       // Eighth zero of a run, pulse
   logic zero16_p;      // Sixteenth zero of a run, pulse
   logic carrier_loss;  // Framer carrier loss, level

   // Core drives pins, reads monitor results
   modport core (output rclk_s, pos_s, neg_s,
                 input  bit_stb, clk_lost, zero8_p, zero16_p,
                        carrier_loss);
   // Clock watchdog
   modport clk_mon (input rclk_s, output bit_stb, clk_lost);
   // Zero run and carrier monitor
   modport line_mon (input bit_stb, pos_s, neg_s,
                     output zero8_p, zero16_p, carrier_loss);
endinterface

`default_nettype wire

// ==== verilog/t1rir_line_mon.sv ====
/*
 * Zero run and framer carrier monitor on the receive rails.
 * Assumes a bit strobe per received bit and synchronised rails;
 * a mark on either rail counts as a one.
 */
`timescale 1ns/1ps
`default_nettype none

module t1rir_line_mon #(
   parameter int unsigned LOSS_ZEROS = t1rir_pkg::ZERO_RUN_LOSS,
   parameter int unsigned ONES_MIN   = t1rir_pkg::ONES_TO_RECOVER,
   parameter int unsigned WINDOW     = t1rir_pkg::RECOVER_WINDOW
) (
   // Clock, reset, enable
   input  wire logic      i_clk,
   input  wire logic      i_rst_b,
   input  wire logic      i_ce,
   // Link to core
   t1rir_line_if.line_mon lnk
);
   localparam int unsigned ZW = $clog2(LOSS_ZEROS + 1);
   localparam int unsigned WW = $clog2(WINDOW + 1);

   initial begin
      if (LOSS_ZEROS <= t1rir_pkg::ZERO_RUN_LONG ||
          ONES_MIN < 1 || ONES_MIN > WINDOW) begin
         $error("line monitor counts out of range");
      end
   end

   logic                     one_bit;          // Mark on a rail
   logic [ZW-1:0]            zrun_q, zrun_d;   // Zero run length
   logic [WW-1:0]            wpos_q, wpos_d;   // Window position
   logic [WW-1:0]            ones_q, ones_d;   // Ones in window
   logic [WW-1:0]            ones_now;         // Ones incl. this bit
   t1rir_pkg::t1rir_carrier_t st_q, st_d;      // Carrier state

   assign one_bit  = lnk.pos_s | lnk.neg_s;
   assign ones_now = ones_q + WW'(one_bit);

   // Run counting and carrier state
   always_comb begin
      zrun_d = zrun_q;
      wpos_d = wpos_q;
      ones_d = ones_q;
      st_d   = st_q;
      if (i_ce && lnk.bit_stb) begin
         if (one_bit) begin
            zrun_d = '0;
         end else if (zrun_q != ZW'(LOSS_ZEROS)) begin
            zrun_d = zrun_q + ZW'(1);
         end
         case (st_q)
            t1rir_pkg::CARRIER_UP: begin
               // Loss after the full zero run
               if (zrun_d == ZW'(LOSS_ZEROS)) begin
                  st_d   = t1rir_pkg::CARRIER_DOWN;
                  wpos_d = '0;
                  ones_d = '0;
               end
            end
            t1rir_pkg::CARRIER_DOWN: begin
               // Windowed ones density ends the loss
               if (wpos_q == WW'(WINDOW - 1)) begin
                  if (ones_now >= WW'(ONES_MIN)) begin
                     st_d = t1rir_pkg::CARRIER_UP;
                  end
                  wpos_d = '0;
                  ones_d = '0;
               end else begin
                  wpos_d = wpos_q + WW'(1);
                  ones_d = ones_now;
               end
            end
            default: begin
               st_d = t1rir_pkg::CARRIER_UP;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         zrun_q <= '0;
         wpos_q <= '0;
         ones_q <= '0;
         st_q   <= t1rir_pkg::CARRIER_UP;
      end else begin
         zrun_q <= zrun_d;
         wpos_q <= wpos_d;
         ones_q <= ones_d;
         st_q   <= st_d;
      end
   end

   // Pulse on reaching each run length
   assign lnk.zero8_p  = i_ce & lnk.bit_stb & ~one_bit &
      (zrun_q == ZW'(t1rir_pkg::ZERO_RUN_SHORT - 1));
   assign lnk.zero16_p = i_ce & lnk.bit_stb & ~one_bit &
      (zrun_q == ZW'(t1rir_pkg::ZERO_RUN_LONG - 1));
   assign lnk.carrier_loss = (st_q == t1rir_pkg::CARRIER_DOWN);
endmodule

`default_nettype wire

// ==== verilog/t1rir_pkg.sv ====
/*
 * Constants for the receive information status block: register
 * addresses, bit positions, line monitor counts and timing.
 * Assumes a 10 MHz system clock; nothing else.
 */
package t1rir_pkg;

   // Register addresses on the parallel control port
   localparam logic [7:0] ADDR_LEVEL_CLOCK   = 8'h10;
   localparam logic [7:0] ADDR_FRAMING_EVT  = 8'h22;
   localparam logic [7:0] ADDR_ALARM_SLIP   = 8'h31;

   // Register indices inside the flag arrays
   localparam int unsigned IDX_FRAMING = 0;
   localparam int unsigned IDX_ALARM   = 1;
   localparam int unsigned IDX_LEVEL   = 2;
   localparam int unsigned NUM_REGS    = 3;

   // Reset value of every latched flag and shadow byte
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   // Value returned for an unmapped address
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // Framing event register bit positions
   localparam int unsigned BIT_ALIGN_CHANGE = 7;
   localparam int unsigned BIT_EIGHT_ZERO   = 6;
   localparam int unsigned BIT_SIXTEEN_ZERO = 5;
   localparam int unsigned BIT_RX_FULL      = 4;
   localparam int unsigned BIT_RX_EMPTY     = 3;
   localparam int unsigned BIT_SEVERE_FRAME = 2;
   localparam int unsigned BIT_B8ZS_CODE    = 1;
   localparam int unsigned BIT_FRAME_BIT    = 0;

   // Alarm clear and slip register bit positions
   localparam int unsigned BIT_SYNC_REGAIN  = 7;
   localparam int unsigned BIT_CARRIER_BACK = 6;
   localparam int unsigned BIT_TX_FULL      = 5;
   localparam int unsigned BIT_TX_EMPTY     = 4;
   localparam int unsigned BIT_TX_SLIP      = 3;
   localparam int unsigned BIT_BLUE_CLEAR   = 2;
   localparam int unsigned BIT_RX_DENSITY   = 1;
   localparam int unsigned BIT_TX_DENSITY   = 0;

   // Level and clock register bit positions
   localparam int unsigned BIT_LEVEL_HIGH   = 7;
   localparam int unsigned BIT_LEVEL_LOW    = 6;
   localparam int unsigned BIT_JITTER_LIMIT = 5;
   localparam int unsigned BIT_CLOCK_LOST   = 4;
   localparam int unsigned BIT_CARRIER_LOSS = 3;
   // Unassigned low bits of the level register
   localparam logic [7:0] LEVEL_UNUSED_MASK = 8'h07;

   // Zero run and carrier recovery counts, in line bits
   localparam int unsigned ZERO_RUN_SHORT   = 8;
   localparam int unsigned ZERO_RUN_LONG    = 16;
   localparam int unsigned ZERO_RUN_LOSS    = 192;
   localparam int unsigned ONES_TO_RECOVER  = 14;
   localparam int unsigned RECOVER_WINDOW   = 112;

   // Receive clock loss timing
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned CLOCK_LOSS_NS    = 2000;
   // Least time, so round up to whole cycles
   localparam int unsigned CLOCK_LOSS_CYC   =
      (CLOCK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Carrier state of the line monitor
   typedef enum logic [0:0] {
      CARRIER_UP   = 1'b0,
      CARRIER_DOWN = 1'b1
   } t1rir_carrier_t;

endpackage

// ==== verilog/t1rir_status.sv ====
/*
 * Receive information status registers: three latched flag bytes
 * read by the host through a mask-write, read, clear-write cycle.
 * Assumes port strobes and event inputs are on the system clock;
 * receive clock and rails are pins and are synchronised here.
 */
// Overview of operation
// - Alignment change after resync sets bit 7.
// - Eight zeros in a row set bit 6.
// - Sixteen zeros in a row set bit 5.
// - Receive store full, frame deleted, bit 4.
// - Receive store empty, frame repeated, bit 3.
// - Two of six framing bits wrong, bit 2.
// - B8ZS codeword seen in any mode, bit 1.
// - Wrong framing bit sets bit 0.
// - Sync regained sets bit 7, held until read.
// - Carrier restored sets bit 6, held until read.
// - Transmit store full, frame deleted, bit 5.
// - Transmit store empty, frame repeated, bit 4.
// - Any transmit slip sets bit 3.
// - Blue alarm ended sets bit 2, held.
// - Receive density violation sets bit 1.
// - Transmit density violation sets bit 0.
// - Two-bit receive level in bits 7:6.
// - Jitter FIFO near limit sets bit 5.
// - Receive clock quiet two microseconds, bit 4.
// - 192 zeros in a row set bit 3.
// - Loss clears after 14 ones in 112.
// - Low three level bits are don't care.
// - Flags latch until read; alarms persist.
// - Mask write refreshes; masked write-back clears.
`timescale 1ns/1ps
`default_nettype none

module t1rir_status #(
   parameter int unsigned LOSS_CYC   = t1rir_pkg::CLOCK_LOSS_CYC,
   parameter int unsigned LOSS_ZEROS = t1rir_pkg::ZERO_RUN_LOSS
) (
   // Clock, reset, enable
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_ce,
   // Parallel control port, synchronous strobes
   input  wire logic       i_bus_wr,
   input  wire logic       i_bus_rd,
   input  wire logic [7:0] i_bus_addr,
   input  wire logic [7:0] i_bus_wdata,
   output logic      [7:0] o_bus_rdata,
   // Receive line pins
   input  wire logic       i_rx_clock_in,
   input  wire logic       i_rx_positive_rail_in,
   input  wire logic       i_rx_negative_rail_in,
   // Framer events, one-cycle pulses
   input  wire logic       i_align_change,
   input  wire logic       i_severe_framing,
   input  wire logic       i_b8zs_code,
   input  wire logic       i_frame_bit_err,
   input  wire logic       i_sync_regained,
   input  wire logic       i_blue_cleared,
   input  wire logic       i_rx_density_viol,
   input  wire logic       i_tx_density_viol,
   // Elastic store events, one-cycle pulses
   input  wire logic       i_rx_store_full,
   input  wire logic       i_rx_store_empty,
   input  wire logic       i_tx_store_full,
   input  wire logic       i_tx_store_empty,
   // Line interface status
   input  wire logic       i_carrier_restored,
   input  wire logic       i_jitter_near_limit,
   input  wire logic [1:0] i_rx_level
);
   localparam int unsigned N = t1rir_pkg::NUM_REGS;

   // Address to register index; valid flag in the top bit
   function automatic logic [2:0] decode(input logic [7:0] a);
      case (a)
         t1rir_pkg::ADDR_FRAMING_EVT: decode = {1'b1, 2'(0)};
         t1rir_pkg::ADDR_ALARM_SLIP:  decode = {1'b1, 2'(1)};
         t1rir_pkg::ADDR_LEVEL_CLOCK: decode = {1'b1, 2'(2)};
         default:                     decode = 3'h0;
      endcase
   endfunction

   // Monitor link
   t1rir_line_if lnk ();

   // Pin synchronisers, two flops each
   logic [2:0] pin_m_q, pin_m_d;     // First stage
   logic [2:0] pin_s_q, pin_s_d;     // Second stage

   // Flag storage
   logic [7:0] latch_q  [N];         // Latched flags
   logic [7:0] latch_d  [N];
   logic [7:0] shadow_q [N];         // Bytes the host reads
   logic [7:0] shadow_d [N];
   logic [7:0] set_v    [N];         // Set terms this cycle
   logic [7:0] rdata_d;              // Next read data
   logic [2:0] wsel;                 // Decoded write/read target

   assign wsel = decode(i_bus_addr);

   // Clock watchdog
   t1rir_clock_mon #(
      .LOSS_CYC (LOSS_CYC)
   ) u_clock_mon (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .lnk     (lnk.clk_mon)
   );

   // Zero run and carrier monitor
   t1rir_line_mon #(
      .LOSS_ZEROS (LOSS_ZEROS),
      .ONES_MIN   (t1rir_pkg::ONES_TO_RECOVER),
      .WINDOW     (t1rir_pkg::RECOVER_WINDOW)
   ) u_line_mon (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_ce    (i_ce),
      .lnk     (lnk.line_mon)
   );

   // Synchroniser next values
   always_comb begin
      pin_m_d = pin_m_q;
      pin_s_d = pin_s_q;
      if (i_ce) begin
         pin_m_d = {i_rx_clock_in, i_rx_positive_rail_in,
                    i_rx_negative_rail_in};
         pin_s_d = pin_m_q;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         pin_m_q <= 3'h0;
         pin_s_q <= 3'h0;
      end else begin
         pin_m_q <= pin_m_d;
         pin_s_q <= pin_s_d;
      end
   end

   assign lnk.rclk_s = pin_s_q[2];
   assign lnk.pos_s  = pin_s_q[1];
   assign lnk.neg_s  = pin_s_q[0];

   // Set terms for each register
   always_comb begin
      for (int i = 0; i < N; i++) begin
         set_v[i] = 8'h00;
      end
      // Framing event register
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_ALIGN_CHANGE] =
         i_align_change;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_EIGHT_ZERO] =
         lnk.zero8_p;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_SIXTEEN_ZERO] =
         lnk.zero16_p;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_RX_FULL] =
         i_rx_store_full;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_RX_EMPTY] =
         i_rx_store_empty;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_SEVERE_FRAME] =
         i_severe_framing;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_B8ZS_CODE] =
         i_b8zs_code;
      set_v[t1rir_pkg::IDX_FRAMING][t1rir_pkg::BIT_FRAME_BIT] =
         i_frame_bit_err;
      // Alarm clear and slip register
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_SYNC_REGAIN] =
         i_sync_regained;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_CARRIER_BACK] =
         i_carrier_restored;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_TX_FULL] =
         i_tx_store_full;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_TX_EMPTY] =
         i_tx_store_empty;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_TX_SLIP] =
         i_tx_store_full | i_tx_store_empty;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_BLUE_CLEAR] =
         i_blue_cleared;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_RX_DENSITY] =
         i_rx_density_viol;
      set_v[t1rir_pkg::IDX_ALARM][t1rir_pkg::BIT_TX_DENSITY] =
         i_tx_density_viol;
      // Level and clock register; levels hold the flag up
      set_v[t1rir_pkg::IDX_LEVEL][t1rir_pkg::BIT_JITTER_LIMIT] =
         i_jitter_near_limit;
      set_v[t1rir_pkg::IDX_LEVEL][t1rir_pkg::BIT_CLOCK_LOST] =
         lnk.clk_lost;
      set_v[t1rir_pkg::IDX_LEVEL][t1rir_pkg::BIT_CARRIER_LOSS] =
         lnk.carrier_loss;
   end

   // Latch, mask-refresh and clear
   always_comb begin
      logic [7:0] clr;
      logic       hit;
      clr     = 8'h00;
      hit     = 1'b0;
      rdata_d = o_bus_rdata;
      for (int i = 0; i < N; i++) begin
         hit = i_ce && i_bus_wr && wsel[2] && (wsel[1:0] == 2'(i));
         // Write-back of bits already shown clears them
         clr = hit ? (i_bus_wdata & shadow_q[i]) : 8'h00;
         latch_d[i] = latch_q[i];
         if (i_ce) begin
            // Set wins over clear; alarms re-set
            latch_d[i] = (latch_q[i] & ~clr) | set_v[i];
         end
      end
      // Level field is live, unassigned bits stay zero
      latch_d[t1rir_pkg::IDX_LEVEL][t1rir_pkg::BIT_LEVEL_HIGH] =
         i_rx_level[1];
      latch_d[t1rir_pkg::IDX_LEVEL][t1rir_pkg::BIT_LEVEL_LOW] =
         i_rx_level[0];
      latch_d[t1rir_pkg::IDX_LEVEL] = latch_d[t1rir_pkg::IDX_LEVEL] &
         ~t1rir_pkg::LEVEL_UNUSED_MASK;
      // Shadow refresh after the level field is final, so a
      // write-back never blanks the live level code
      for (int i = 0; i < N; i++) begin
         hit = i_ce && i_bus_wr && wsel[2] && (wsel[1:0] == 2'(i));
         shadow_d[i] = shadow_q[i];
         if (hit) begin
            // Refresh ones in the mask, hold zeros
            shadow_d[i] = (shadow_q[i] & ~i_bus_wdata) |
                          (latch_d[i] & i_bus_wdata);
         end
      end
      // Read data registered one cycle after the strobe
      if (i_ce && i_bus_rd) begin
         rdata_d = wsel[2] ? shadow_q[wsel[1:0]]
                           : t1rir_pkg::UNMAPPED_DATA;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int i = 0; i < N; i++) begin
            latch_q[i]  <= t1rir_pkg::FLAGS_RESET;
            shadow_q[i] <= t1rir_pkg::FLAGS_RESET;
         end
         o_bus_rdata <= t1rir_pkg::UNMAPPED_DATA;
      end else begin
         for (int i = 0; i < N; i++) begin
            latch_q[i]  <= latch_d[i];
            shadow_q[i] <= shadow_d[i];
         end
         o_bus_rdata <= rdata_d;
      end
   end
endmodule

`default_nettype wire
